/* logic/utb_uart.sv */
// How it works
// - Full duplex serial port with 8-bit and 9-bit frames, variable baud.
// - A completed byte is buffered while the next one shifts in.
// - A data buffer write loads the transmit register and starts sending.
// - Data buffer reads return the receive buffer, never the transmit one.
// - Interrupt is requested when enabled and either done flag is set.
// - Done flags are cleared only by software, never by servicing.
// - Transmit timing comes from low count overflows, reloaded from reload value.
// - A hidden receive copy of the low count runs with the timer enabled.
// - Both overflow streams are divided by two for the bit rates.
// - A detected start bit forces a reload of the receive timer.
// - Timer clock is core_system_clock/1, /4, /12, /48, ext osc/8 or ext input.
// - 8-bit frame: start, eight data LSB first, stop; stop stored as ninth.
// - 9-bit frame adds the ninth bit from software; received ninth stored.
// - Transmit done is set at the beginning of the stop bit.
// - Load byte and set receive done only if flag clear and mp check passes.
`default_nettype none
module utb_uart (
	input wire logic ref_clk,
	input wire logic srst,
	input wire utb_pkg::utb_ctrl_s ctrl,
	input wire logic timer_enable,
	input wire utb_pkg::utb_clksel_e clk_select,
	input wire logic ext_osc_tick,
	input wire logic external_timer_input,
	input wire logic [7:0] baud_timer_reload_value,
	input wire logic [7:0] wr_data,
	input wire logic wr_strobe,
	input wire logic tx_done_clear,
	input wire logic rx_done_clear,
	input wire logic serial_int_enable,
	input wire logic rx_pin,
	output logic tx_pin,
	output logic [7:0] serial_data_buffer,
	output logic ninth_receive_bit,
	output logic tx_done_flag,
	output logic rx_done_flag,
	output logic [7:0] baud_timer_low_count,
	output logic tx_busy,
	output logic serial_irq
);
	import utb_pkg::*;

	typedef enum logic [1:0] {
		UTB_RX_IDLE = 2'b01,
		UTB_RX_BUSY = 2'b10
	} utb_rxst_e;

	logic [5:0] presc_r, presc_nxt;
	logic [2:0] osc_r, osc_nxt;
	logic ext_d_r, ext_d_nxt;
	logic tick;
	logic [7:0] txt_r, txt_nxt, rxt_r, rxt_nxt;
	logic tx_half_r, tx_half_nxt, rx_half_r, rx_half_nxt;
	logic tx_ovf, rx_ovf, tx_baud, rx_baud;
	logic [10:0] tx_sh_r, tx_sh_nxt;
	logic [3:0] tx_cnt_r, tx_cnt_nxt;
	logic tx_act_r, tx_act_nxt, tx_pin_nxt;
	logic txf_r, txf_nxt, rxf_r, rxf_nxt;
	utb_rxst_e rx_st_r, rx_st_nxt;
	logic [3:0] rx_cnt_r, rx_cnt_nxt;
	logic [8:0] rx_sh_r, rx_sh_nxt;
	logic rx_prev_r, rx_prev_nxt;
	logic [7:0] buf_r, buf_nxt;
	logic rb8_r, rb8_nxt;
	logic start_det;
	logic [3:0] last_bit;

	// Timer clock source selection and prescaling.
	always_comb begin
		presc_nxt = (presc_r == PRESC_48) ? 6'h00 : presc_r + 6'h01;
		osc_nxt = ext_osc_tick ? osc_r + 3'h1 : osc_r;
		ext_d_nxt = external_timer_input;
		tick = 1'b0;
		unique case (clk_select)
			UTB_CLK_SYS: tick = 1'b1;
			UTB_CLK_DIV4: tick = (presc_r[1:0] == PRESC_4[1:0]);
			UTB_CLK_DIV12: tick = (presc_r == PRESC_12) ||
				(presc_r == PRESC_12 + 6'h0c) ||
				(presc_r == PRESC_12 + 6'h18) || (presc_r == PRESC_48);
			UTB_CLK_DIV48: tick = (presc_r == PRESC_48);
			UTB_CLK_EXTOSC8: tick = ext_osc_tick && (osc_r == PRESC_EXT8);
			UTB_CLK_EXTIN: tick = ext_d_r && !external_timer_input;
			default: tick = 1'b0;
		endcase
		tick = tick && timer_enable;
	end

	// Baud timers: visible low count for transmit, hidden copy for receive.
	always_comb begin
		start_det = (rx_st_r == UTB_RX_IDLE) && ctrl.receive_enable_bit &&
			rx_prev_r && !rx_pin;
		tx_ovf = tick && (txt_r == TIMER_TOP);
		rx_ovf = tick && (rxt_r == TIMER_TOP);
		txt_nxt = tick ? (tx_ovf ? baud_timer_reload_value : txt_r + 8'h01)
			: txt_r;
		rxt_nxt = tick ? (rx_ovf ? baud_timer_reload_value : rxt_r + 8'h01)
			: rxt_r;
		tx_half_nxt = tx_ovf ? !tx_half_r : tx_half_r;
		rx_half_nxt = rx_ovf ? !rx_half_r : rx_half_r;
		if (start_det) begin
			rxt_nxt = baud_timer_reload_value;
			rx_half_nxt = 1'b0;
		end
		tx_baud = tx_ovf && tx_half_r;
		rx_baud = rx_ovf && rx_half_r;
	end

	// Transmitter and its done flag.
	always_comb begin
		tx_sh_nxt = tx_sh_r;
		tx_cnt_nxt = tx_cnt_r;
		tx_act_nxt = tx_act_r;
		tx_pin_nxt = tx_pin;
		txf_nxt = txf_r;
		if (tx_done_clear) begin
			txf_nxt = 1'b0;
		end
		if (wr_strobe) begin
			tx_sh_nxt = {1'b1, ctrl.ninth_transmit_bit, wr_data, 1'b0};
			if (!ctrl.frame_mode_select) begin
				tx_sh_nxt[9] = 1'b1;
			end
			tx_cnt_nxt = 4'h0;
			tx_act_nxt = 1'b1;
		end else if (tx_act_r && tx_baud) begin
			tx_pin_nxt = tx_sh_r[0];
			tx_sh_nxt = {1'b1, tx_sh_r[10:1]};
			tx_cnt_nxt = tx_cnt_r + 4'h1;
			if (tx_cnt_r == (ctrl.frame_mode_select ? FRAME_BITS_9
					: FRAME_BITS_8)) begin
				txf_nxt = 1'b1;
				tx_act_nxt = 1'b0;
			end
		end
	end

	// Receiver with one-byte buffer, sampled once mid-bit by half-rate phase.
	always_comb begin
		last_bit = ctrl.frame_mode_select ? FRAME_BITS_9 : FRAME_BITS_8;
		rx_st_nxt = rx_st_r;
		rx_cnt_nxt = rx_cnt_r;
		rx_sh_nxt = rx_sh_r;
		rx_prev_nxt = rx_pin;
		buf_nxt = buf_r;
		rb8_nxt = rb8_r;
		rxf_nxt = rxf_r;
		if (rx_done_clear) begin
			rxf_nxt = 1'b0;
		end
		unique case (rx_st_r)
			UTB_RX_IDLE: begin
				if (start_det) begin
					rx_st_nxt = UTB_RX_BUSY;
					rx_cnt_nxt = 4'h0;
				end
			end
			UTB_RX_BUSY: begin
				if (rx_ovf && !rx_half_r) begin
					rx_cnt_nxt = rx_cnt_r + 4'h1;
					if (rx_cnt_r == 4'h0 && rx_pin) begin
						rx_st_nxt = UTB_RX_IDLE;
					end else if (rx_cnt_r != 4'h0 && rx_cnt_r < last_bit) begin
						rx_sh_nxt = {rx_pin, rx_sh_r[8:1]};
					end
					if (rx_cnt_r == last_bit) begin
						rx_st_nxt = UTB_RX_IDLE;
						// Ninth bit is the stop bit in 8-bit mode.
						if (!rxf_r && (!ctrl.multiproc_enable ||
							(ctrl.frame_mode_select ? rx_sh_r[8] : rx_pin))) begin
							buf_nxt = ctrl.frame_mode_select ? rx_sh_r[7:0]
								: rx_sh_r[8:1];
							rb8_nxt = ctrl.frame_mode_select ? rx_sh_r[8] : rx_pin;
							rxf_nxt = 1'b1;
						end
					end
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			presc_r <= 6'h00;
			osc_r <= 3'h0;
			ext_d_r <= 1'b0;
			txt_r <= RELOAD_RST;
			rxt_r <= RELOAD_RST;
			tx_half_r <= 1'b0;
			rx_half_r <= 1'b0;
			tx_sh_r <= 11'h7ff;
			tx_cnt_r <= 4'h0;
			tx_act_r <= 1'b0;
			tx_pin <= 1'b1;
			txf_r <= 1'b0;
			rxf_r <= 1'b0;
			rx_st_r <= UTB_RX_IDLE;
			rx_cnt_r <= 4'h0;
			rx_sh_r <= 9'h000;
			rx_prev_r <= 1'b1;
			buf_r <= BUF_RST;
			rb8_r <= 1'b0;
		end else begin
			presc_r <= presc_nxt;
			osc_r <= osc_nxt;
			ext_d_r <= ext_d_nxt;
			txt_r <= txt_nxt;
			rxt_r <= rxt_nxt;
			tx_half_r <= tx_half_nxt;
			rx_half_r <= rx_half_nxt;
			tx_sh_r <= tx_sh_nxt;
			tx_cnt_r <= tx_cnt_nxt;
			tx_act_r <= tx_act_nxt;
			tx_pin <= tx_pin_nxt;
			txf_r <= txf_nxt;
			rxf_r <= rxf_nxt;
			rx_st_r <= rx_st_nxt;
			rx_cnt_r <= rx_cnt_nxt;
			rx_sh_r <= rx_sh_nxt;
			rx_prev_r <= rx_prev_nxt;
			buf_r <= buf_nxt;
			rb8_r <= rb8_nxt;
		end
	end

	assign serial_data_buffer = buf_r;
	assign ninth_receive_bit = rb8_r;
	assign tx_done_flag = txf_r;
	assign rx_done_flag = rxf_r;
	assign baud_timer_low_count = txt_r;
	assign tx_busy = tx_act_r;
	assign serial_irq = serial_int_enable && (txf_r || rxf_r);
endmodule : utb_uart
`default_nettype wire

/* logic/utb_pkg.sv */
`default_nettype none
package utb_pkg;
	localparam int unsigned DATA_W = 8;
	localparam logic [7:0] BUF_RST = 8'h00;
	localparam logic [7:0] RELOAD_RST = 8'h00;
	localparam logic [7:0] TIMER_TOP = 8'hff;
	localparam logic [3:0] FRAME_BITS_8 = 4'h9;
	localparam logic [3:0] FRAME_BITS_9 = 4'ha;
	localparam logic [3:0] SAMPLE_MID = 4'h8;
	localparam logic [5:0] PRESC_4 = 6'h03;
	localparam logic [5:0] PRESC_12 = 6'h0b;
	localparam logic [5:0] PRESC_48 = 6'h2f;
	localparam logic [2:0] PRESC_EXT8 = 3'h7;

	typedef enum logic [2:0] {
		UTB_CLK_SYS = 3'h0,
		UTB_CLK_DIV4 = 3'h1,
		UTB_CLK_DIV12 = 3'h2,
		UTB_CLK_DIV48 = 3'h3,
		UTB_CLK_EXTOSC8 = 3'h4,
		UTB_CLK_EXTIN = 3'h5
	} utb_clksel_e;

	typedef struct packed {
		logic frame_mode_select;
		logic multiproc_enable;
		logic receive_enable_bit;
		logic ninth_transmit_bit;
	} utb_ctrl_s;
endpackage : utb_pkg
`default_nettype wire

/* testbench/utb_uart_assertions.sv */
`default_nettype none
module utb_uart_chk (
	input wire logic ref_clk,
	input wire logic srst,
	input wire utb_pkg::utb_clksel_e clk_select,
	input wire logic timer_enable,
	input wire logic [7:0] baud_timer_reload_value,
	input wire logic wr_strobe,
	input wire logic tx_done_clear,
	input wire logic rx_done_clear,
	input wire logic serial_int_enable,
	input wire logic tx_pin,
	input wire logic [7:0] serial_data_buffer,
	input wire logic tx_done_flag,
	input wire logic rx_done_flag,
	input wire logic [7:0] baud_timer_low_count,
	input wire logic tx_busy,
	input wire logic serial_irq
);
	timeunit 1ns;
	timeprecision 1ns;
	import utb_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	a_irq_follows_flags: assert property (
		serial_irq == (serial_int_enable & (tx_done_flag | rx_done_flag)))
		else $error("irq wrong");
	a_tx_flag_sticky: assert property (
		tx_done_flag && !tx_done_clear |=> tx_done_flag) else $error("tx flag");
	a_rx_flag_sticky: assert property (
		rx_done_flag && !rx_done_clear |=> rx_done_flag) else $error("rx flag");
	a_buffer_held: assert property (
		rx_done_flag && !rx_done_clear |=> $stable(serial_data_buffer))
		else $error("buffer changed");
	a_write_starts: assert property (
		wr_strobe |=> tx_busy) else $error("no start");
	a_done_at_stop: assert property (
		$rose(tx_done_flag) |-> tx_pin && $fell(tx_busy)) else $error("done");
	a_idle_high: assert property (
		!tx_busy |-> tx_pin) else $error("idle low");
	a_low_reload: assert property (
		timer_enable && clk_select == UTB_CLK_SYS &&
		baud_timer_low_count == TIMER_TOP
		|=> baud_timer_low_count == $past(baud_timer_reload_value))
		else $error("reload");
endmodule : utb_uart_chk
bind utb_uart utb_uart_chk u_chk (.ref_clk, .srst, .clk_select,
	.timer_enable, .baud_timer_reload_value, .wr_strobe, .tx_done_clear,
	.rx_done_clear, .serial_int_enable, .tx_pin, .serial_data_buffer,
	.tx_done_flag, .rx_done_flag, .baud_timer_low_count, .tx_busy,
	.serial_irq);
`default_nettype wire

/* testbench/utb_line_model.sv */
`default_nettype none
module utb_line_model #(
	parameter int BIT = 32
) (
	input wire logic ref_clk,
	output var logic rx_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	initial rx_pin = 1'b1;
	task send(input logic [10:0] f, input int nb);
		for (int i = 0; i < nb; i++) begin
			rx_pin <= f[i];
			repeat (BIT) @(posedge ref_clk);
		end
		rx_pin <= 1'b1;
	endtask : send
endmodule : utb_line_model
`default_nettype wire

/* testbench/tb_utb_uart.sv */
`default_nettype none
module tb_utb_uart;
	timeunit 1ns;
	timeprecision 1ns;
	import utb_pkg::*;
	localparam int BIT = 32;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	utb_ctrl_s ctrl = '0;
	utb_clksel_e clk_select = UTB_CLK_SYS;
	logic timer_enable = 1'b0;
	logic wr_strobe = 1'b0;
	logic tx_done_clear = 1'b0;
	logic rx_done_clear = 1'b0;
	logic serial_int_enable = 1'b0;
	logic [7:0] wr_data = 8'h00;
	logic [7:0] reload = 8'hf0;
	logic ext_tgl = 1'b0;
	wire logic [7:0] low_count;
	wire logic rx_pin, tx_pin, ninth_receive_bit, tx_busy, serial_irq;
	wire logic tx_done_flag, rx_done_flag;
	wire logic [7:0] serial_data_buffer;
	int fail_count = 0;
	int checks = 0;
	int cyc = 0;
	always #25 ref_clk = ~ref_clk;
	always @(posedge ref_clk) ext_tgl <= ~ext_tgl;
	utb_uart DUT (.ref_clk, .srst, .ctrl, .timer_enable, .clk_select,
		.ext_osc_tick(ext_tgl), .external_timer_input(ext_tgl),
		.baud_timer_reload_value(reload), .wr_data, .wr_strobe,
		.tx_done_clear, .rx_done_clear, .serial_int_enable, .rx_pin,
		.tx_pin, .serial_data_buffer, .ninth_receive_bit, .tx_done_flag,
		.rx_done_flag, .baud_timer_low_count(low_count), .tx_busy,
		.serial_irq);
	utb_line_model #(.BIT(BIT)) u_line (.ref_clk, .rx_pin);
	task cmp(input string n, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask : cmp
	task close_out;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : close_out
	function automatic logic [10:0] fr(input logic [7:0] d, input logic n9);
		return ctrl.frame_mode_select ? {1'b1, n9, d, 1'b0} : {2'b11, d, 1'b0};
	endfunction : fr
	task tx(input logic [7:0] d);
		logic [10:0] f;
		@(posedge ref_clk);
		f = fr(d, ctrl.ninth_transmit_bit);
		wr_data <= d;
		wr_strobe <= 1'b1;
		@(posedge ref_clk);
		wr_strobe <= 1'b0;
		@(negedge ref_clk);
		cmp("busy", 1, tx_busy);
		for (int i = 0; i < 400 && tx_pin; i++) @(negedge ref_clk);
		repeat (BIT / 2) @(negedge ref_clk);
		for (int k = 0; k < 10 + ctrl.frame_mode_select; k++) begin
			cmp("tx_pin", f[k], tx_pin);
			repeat (BIT) @(negedge ref_clk);
		end
		cmp("tx_done", 1, tx_done_flag);
		cmp("busy", 0, tx_busy);
	endtask : tx
	task rx(input logic [7:0] d, input logic n9);
		@(posedge ref_clk);
		u_line.send(fr(d, n9), 10 + ctrl.frame_mode_select);
		@(negedge ref_clk);
	endtask : rx
	task clr;
		@(posedge ref_clk);
		tx_done_clear <= 1'b1;
		rx_done_clear <= 1'b1;
		@(posedge ref_clk);
		tx_done_clear <= 1'b0;
		rx_done_clear <= 1'b0;
		@(negedge ref_clk);
		cmp("flags", 0, {tx_done_flag, rx_done_flag});
	endtask : clr
	task rate(input utb_clksel_e s, input logic [7:0] e);
		logic [7:0] a;
		@(posedge ref_clk);
		clk_select <= s;
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		a = low_count;
		repeat (96) @(negedge ref_clk);
		cmp("low_count", e, low_count - a);
	endtask : rate
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			close_out;
		end
	end
	initial begin
		repeat (4) @(posedge ref_clk);
		srst <= 1'b0;
		timer_enable <= 1'b1;
		ctrl <= 4'b0010;
		@(negedge ref_clk);
		cmp("idle", 1, tx_pin);
		cmp("buf", 0, serial_data_buffer);
		cmp("flags", 0, {tx_done_flag, rx_done_flag});
		$display("test reset done");
		tx(8'ha5);
		cmp("buf", 0, serial_data_buffer);
		cmp("irq", 0, serial_irq);
		@(posedge ref_clk);
		serial_int_enable <= 1'b1;
		@(negedge ref_clk);
		cmp("irq", 1, serial_irq);
		clr;
		@(posedge ref_clk);
		ctrl <= 4'b1011;
		tx(8'h3c);
		clr;
		$display("test transmit done");
		@(posedge ref_clk);
		ctrl <= 4'b0010;
		rx(8'h5a, 1'b0);
		cmp("buf", 8'h5a, serial_data_buffer);
		cmp("ninth", 1, ninth_receive_bit);
		cmp("irq", 1, serial_irq);
		rx(8'hc3, 1'b0);
		cmp("buf", 8'h5a, serial_data_buffer);
		clr;
		@(posedge ref_clk);
		ctrl <= 4'b1110;
		rx(8'h11, 1'b0);
		cmp("rx_done", 0, rx_done_flag);
		rx(8'h22, 1'b1);
		cmp("buf", 8'h22, serial_data_buffer);
		cmp("ninth", 1, ninth_receive_bit);
		$display("test receive done");
		@(posedge ref_clk);
		reload <= 8'h00;
		rate(UTB_CLK_SYS, 8'h60);
		rate(UTB_CLK_DIV4, 8'h18);
		rate(UTB_CLK_DIV12, 8'h08);
		rate(UTB_CLK_DIV48, 8'h02);
		rate(UTB_CLK_EXTOSC8, 8'h06);
		rate(UTB_CLK_EXTIN, 8'h30);
		$display("test timer clock done");
		close_out;
	end
endmodule : tb_utb_uart
`default_nettype wire
